// ===== rtl/cl_cfg_map.svh
/*
 holds offsets, field positions, reset values and timing figures of the
 closed-loop stop and gain configuration bank.
 assumes inclusion by bare name from the design file.
*/
`ifndef CL_CFG_MAP_SVH
`define CL_CFG_MAP_SVH

// offsets are word indices; byte address = 4 * index
`define STOP_REG_IDX 8'h8a
`define GAIN_REG_IDX 8'h8c
`define STATUS_REG_IDX 8'h90
`define STOP_REG_ADDR 10'h228
`define GAIN_REG_ADDR 10'h230
`define STATUS_REG_ADDR 10'h240
`define SPD_LSB_REG_ADDR 10'h238
`define TOP_SPEED_REG_ADDR 10'h238
// reset values; unknown-at-reset fields reset to zero here
`define STOP_REG_RESET 32'h0000_0000
`define GAIN_REG_RESET 32'h0000_0000
`define SPD_LSB_RESET 7'h00
`define TOP_SPEED_RESET 14'h0000
// field positions
`define STOP_METHOD_MSB 30
`define STOP_METHOD_LSB 28
`define BRAKE_DUR_MSB 27
`define BRAKE_DUR_LSB 24
`define SPIN_THR_MSB 23
`define SPIN_THR_LSB 20
`define BRAKE_THR_MSB 19
`define BRAKE_THR_LSB 16
`define RES_MSB 15
`define RES_LSB 8
`define IND_MSB 7
`define IND_LSB 0
`define BEMF_MSB 30
`define BEMF_LSB 23
`define CUR_KP_MSB 22
`define CUR_KP_LSB 13
`define CUR_KI_MSB 12
`define CUR_KI_LSB 3
`define SPD_KP_HI_MSB 2
`define SPD_KP_HI_LSB 0
// brake duration table end points, in ms
`define BRAKE_MS_MIN 14'd1
`define BRAKE_MS_MAX 14'd15000
// thresholds held in tenths of a percent so that 2.5 % stays exact
`define PCT_X10_MAX 10'd1000
`define PCT_X10_MIN 10'd25

`endif

// ===== rtl/cl_cfg_pkg.sv
/*
 types of the closed-loop stop and gain configuration bank.
 holds its own enum codes; takes no numbers from cl_cfg_map.svh.
*/
package cl_cfg_pkg;

  typedef enum logic [2:0] {
    STOP_HIZ = 3'h0,
    STOP_RSVD = 3'h1,
    STOP_LOW_BRAKE = 3'h2,
    STOP_HIGH_BRAKE = 3'h3,
    STOP_SPIN_DOWN = 3'h4,
    STOP_ALIGN_BRAKE = 3'h5,
    STOP_UNDEF6 = 3'h6,
    STOP_UNDEF7 = 3'h7
  } stop_method_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  // decoded configuration handed to the control loops
  typedef struct packed {
    stop_method_e motor_stop_method;
    logic stop_valid;
    logic brake_stop;
    logic [13:0] stop_brake_duration_ms;
    logic [9:0] active_spindown_speed_level_x10;
    logic [9:0] brake_speed_level_x10;
    logic [13:0] spindown_speed_hz;
    logic [13:0] brake_speed_hz;
    logic [7:0] phase_resistance_code;
    logic [7:0] phase_inductance_code;
    logic [7:0] back_emf_constant_code;
    logic [9:0] current_proportional_gain;
    logic [9:0] current_integral_gain;
    logic current_gain_auto;
    logic [9:0] speed_proportional_gain;
  } cl_cfg_s;

endpackage

// ===== rtl/cl_cfg_regs.sv
/*
 holds the closed-loop stop/brake and loop-gain configuration words, an apb
 slave to reach them, and the decode of every field for the control loops.
 assumes an apb master on i_clk_sys; the speed-loop gain low bits and the
 top speed limit come in from the neighbouring register as plain inputs
 on the same clock.
*/
// Our own choice: the APB slave port.
// Operation
// - decode stop method, flag reserved/undefined codes
// - map brake duration code to milliseconds
// - spin-down threshold as percent of top speed
// - brake threshold, same encoding, for braking stops
// - hold phase resistance code bits 15:8
// - hold phase inductance code bits 7:0
// - hold back-emf constant code bits 30:23
// - current proportional gain at bits 22:13
// - current integral gain at bits 12:3
// - zero current gains select automatic calculation
// - bits 2:0 are speed gain upper bits
// - join seven low speed gain bits
// - thresholds scale the 14-bit top speed
`timescale 1ns/1ps
`default_nettype none
`include "cl_cfg_map.svh"

// one read-write configuration word; every bit stored, none decoded here
module cfg_word #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic [WIDTH-1:0] o_word
);

  logic [WIDTH-1:0] word_q;
  logic [WIDTH-1:0] word_d;

  // a write replaces the whole word; the bus has no byte strobes
  assign word_d = i_wr_en ? i_wr_data : word_q;

  // synchronous reset to the word's reset value
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      word_q <= RESET;
    end else begin
      word_q <= word_d;
    end
  end

  assign o_word = word_q;

endmodule

// sixteen-step speed threshold: tenths of a percent, then scaled to hz
module speed_level_scale (
  input wire logic [3:0] i_code,
  input wire logic [13:0] i_top_speed_hz,
  output logic [9:0] o_pct_x10,
  output logic [13:0] o_speed_hz
);

  logic [9:0] pct_x10;
  wire [23:0] prod;
  wire [23:0] quot;

  // tenths keep the 2.5 % step exact without a fraction
  always_comb begin
    pct_x10 = `PCT_X10_MAX;
    unique case (i_code)
      4'h0: pct_x10 = `PCT_X10_MAX;
      4'h1: pct_x10 = 10'd900;
      4'h2: pct_x10 = 10'd800;
      4'h3: pct_x10 = 10'd700;
      4'h4: pct_x10 = 10'd600;
      4'h5: pct_x10 = 10'd500;
      4'h6: pct_x10 = 10'd450;
      4'h7: pct_x10 = 10'd400;
      4'h8: pct_x10 = 10'd350;
      4'h9: pct_x10 = 10'd300;
      4'ha: pct_x10 = 10'd250;
      4'hb: pct_x10 = 10'd200;
      4'hc: pct_x10 = 10'd150;
      4'hd: pct_x10 = 10'd100;
      4'he: pct_x10 = 10'd50;
      4'hf: pct_x10 = `PCT_X10_MIN;
    endcase
  end

  // top speed times tenths over 1000; truncates toward zero
  // worst case 16383 * 1000 still fits in 24 bits, quotient in 14
  assign prod = {10'h000, i_top_speed_hz} * {14'h0000, pct_x10};
  assign quot = prod / 24'd1000;
  assign o_pct_x10 = pct_x10;
  assign o_speed_hz = quot[13:0];

endmodule

module cl_cfg_regs (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire cl_cfg_pkg::apb_req_s i_apb,
  output cl_cfg_pkg::apb_rsp_s o_apb,
  input wire logic [6:0] i_speed_gain_low,
  input wire logic [13:0] i_top_speed_hz,
  output cl_cfg_pkg::cl_cfg_s o_cfg
);

  logic [31:0] stop_reg_q;
  logic [31:0] gain_reg_q;
  logic [9:0] spin_pct;
  logic [9:0] brk_pct;
  logic [13:0] spin_hz;
  logic [13:0] brk_hz;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  cl_cfg_pkg::cl_cfg_s cfg_q;
  cl_cfg_pkg::cl_cfg_s cfg_d;

  // apb decode; one wait-free access phase, reads answer from a flop
  wire access = i_apb.psel & i_apb.penable;
  wire sel_stop = (i_apb.paddr == `STOP_REG_ADDR);
  wire sel_gain = (i_apb.paddr == `GAIN_REG_ADDR);
  wire sel_status = (i_apb.paddr == `STATUS_REG_ADDR);
  wire mapped = sel_stop | sel_gain | sel_status;
  wire setup = i_apb.psel & ~i_apb.penable;
  wire wr_stop = access & i_apb.pwrite & sel_stop;
  wire wr_gain = access & i_apb.pwrite & sel_gain;

  // readable state of the block: decoded stop status, auto-gain flag and speed proportional gain
  wire [31:0] status_word = {16'h0000, cfg_q.current_gain_auto,
    cfg_q.brake_stop, cfg_q.stop_valid, cfg_q.motor_stop_method,
    cfg_q.speed_proportional_gain};

  // the two words; bit 31 stored with no effect
  cfg_word #(
    .WIDTH(32),
    .RESET(`STOP_REG_RESET)
  ) i_cfg_word_stop (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_wr_en(wr_stop),
    .i_wr_data(i_apb.pwdata),
    .o_word(stop_reg_q)
  );
  cfg_word #(
    .WIDTH(32),
    .RESET(`GAIN_REG_RESET)
  ) i_cfg_word_gain (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_wr_en(wr_gain),
    .i_wr_data(i_apb.pwdata),
    .o_word(gain_reg_q)
  );

  // read data prepared in setup so it is stable through the access phase
  assign prdata_d = ~setup ? prdata_q :
    sel_stop ? stop_reg_q :
    sel_gain ? gain_reg_q :
    sel_status ? status_word : 32'h0000_0000;
  assign pslverr_d = setup ? ~mapped : pslverr_q;

  // zero wait states: every access phase completes in one cycle
  assign o_apb = '{prdata: prdata_q, pready: 1'b1, pslverr: pslverr_q & access};

  // field views
  wire [2:0] stop_code = stop_reg_q[`STOP_METHOD_MSB:`STOP_METHOD_LSB];
  wire [3:0] dur_code = stop_reg_q[`BRAKE_DUR_MSB:`BRAKE_DUR_LSB];
  wire [3:0] spin_code = stop_reg_q[`SPIN_THR_MSB:`SPIN_THR_LSB];
  wire [3:0] brk_code = stop_reg_q[`BRAKE_THR_MSB:`BRAKE_THR_LSB];
  wire [9:0] cur_kp = gain_reg_q[`CUR_KP_MSB:`CUR_KP_LSB];
  wire [9:0] cur_ki = gain_reg_q[`CUR_KI_MSB:`CUR_KI_LSB];
  wire [2:0] spd_hi = gain_reg_q[`SPD_KP_HI_MSB:`SPD_KP_HI_LSB];

  // brake duration table, ms; codes 0..4 all give the minimum
  function automatic logic [13:0] brake_ms(input logic [3:0] code);
    logic [13:0] ms;
    ms = `BRAKE_MS_MIN;
    unique case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: ms = `BRAKE_MS_MIN;
      4'h5: ms = 14'd5;
      4'h6: ms = 14'd10;
      4'h7: ms = 14'd50;
      4'h8: ms = 14'd100;
      4'h9: ms = 14'd250;
      4'ha: ms = 14'd500;
      4'hb: ms = 14'd1000;
      4'hc: ms = 14'd2500;
      4'hd: ms = 14'd5000;
      4'he: ms = 14'd10000;
      4'hf: ms = `BRAKE_MS_MAX;
    endcase
    return ms;
  endfunction

  // one threshold decoder instance per field, both against the same top speed
  speed_level_scale i_speed_level_scale_spin (
    .i_code(spin_code),
    .i_top_speed_hz(i_top_speed_hz),
    .o_pct_x10(spin_pct),
    .o_speed_hz(spin_hz)
  );
  speed_level_scale i_speed_level_scale_brake (
    .i_code(brk_code),
    .i_top_speed_hz(i_top_speed_hz),
    .o_pct_x10(brk_pct),
    .o_speed_hz(brk_hz)
  );

  // decoded configuration; registered so loop-side outputs come from flops
  always_comb begin
    cfg_d = '0;
    cfg_d.motor_stop_method = cl_cfg_pkg::stop_method_e'(stop_code);
    // reserved and undefined codes flagged so the loop can fall back
    cfg_d.stop_valid = (stop_code != 3'h1) && (stop_code < 3'h6);
    // brake threshold only governs the three braking stops
    cfg_d.brake_stop = (stop_code == 3'h2) || (stop_code == 3'h3) ||
      (stop_code == 3'h5);
    cfg_d.stop_brake_duration_ms = brake_ms(dur_code);
    cfg_d.active_spindown_speed_level_x10 = spin_pct;
    cfg_d.brake_speed_level_x10 = brk_pct;
    cfg_d.spindown_speed_hz = spin_hz;
    cfg_d.brake_speed_hz = brk_hz;
    cfg_d.phase_resistance_code = stop_reg_q[`RES_MSB:`RES_LSB];
    cfg_d.phase_inductance_code = stop_reg_q[`IND_MSB:`IND_LSB];
    cfg_d.back_emf_constant_code = gain_reg_q[`BEMF_MSB:`BEMF_LSB];
    cfg_d.current_proportional_gain = cur_kp;
    cfg_d.current_integral_gain = cur_ki;
    // both fields zero hands the current gains to the auto tuner
    cfg_d.current_gain_auto = (cur_kp == 10'h000) && (cur_ki == 10'h000);
    cfg_d.speed_proportional_gain = {spd_hi, i_speed_gain_low};
  end

  // bus response flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // decoded view, one clock behind the words so loop outputs are flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign o_cfg = cfg_q;

endmodule

`default_nettype wire

// ===== verif/cl_cfg_regs_assertions.sv
/*
 port checker of the closed-loop stop and gain configuration bank.
 assumes a bind onto cl_cfg_regs, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cl_cfg_regs_assertions (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire cl_cfg_pkg::apb_req_s i_apb,
  input wire cl_cfg_pkg::apb_rsp_s o_apb,
  input wire logic [6:0] i_speed_gain_low,
  input wire logic [13:0] i_top_speed_hz,
  input wire cl_cfg_pkg::cl_cfg_s o_cfg
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // access phase and address decode
  wire acc = i_apb.psel & i_apb.penable;
  wire mapped = i_apb.paddr inside {10'h228, 10'h230, 10'h240};
  sequence wr_stop; acc && i_apb.pwrite && i_apb.paddr == 10'h228; endsequence
  sequence wr_gain; acc && i_apb.pwrite && i_apb.paddr == 10'h230; endsequence
  a_ready_high: assert property (o_apb.pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> o_apb.pslverr)
    else $error("no slverr");
  a_err_mapped: assert property (acc && mapped |-> !o_apb.pslverr)
    else $error("bad slverr");
  // decoded flags follow the held codes; first edge after reset still shows zeros
  a_stop_decode: assert property ($past(i_rstn) |->
    o_cfg.stop_valid == !(o_cfg.motor_stop_method inside {3'h1, 3'h6, 3'h7}) &&
    o_cfg.brake_stop == (o_cfg.motor_stop_method inside {3'h2, 3'h3, 3'h5}))
    else $error("stop decode");
  a_gain_auto: assert property ($past(i_rstn) |-> o_cfg.current_gain_auto ==
    (o_cfg.current_proportional_gain == 0 && o_cfg.current_integral_gain == 0))
    else $error("auto gain flag");
  a_spd_join: assert property ($past(i_rstn) |->
    o_cfg.speed_proportional_gain[6:0] == $past(i_speed_gain_low)) else $error("kp low");
  // a write lands at the access edge, the decode one edge later
  a_stop_fields: assert property (wr_stop |-> ##2
    o_cfg.motor_stop_method == $past(i_apb.pwdata[30:28], 2) &&
    o_cfg.phase_resistance_code == $past(i_apb.pwdata[15:8], 2) &&
    o_cfg.phase_inductance_code == $past(i_apb.pwdata[7:0], 2))
    else $error("stop fields");
  a_gain_fields: assert property (wr_gain |-> ##2
    o_cfg.back_emf_constant_code == $past(i_apb.pwdata[30:23], 2) &&
    o_cfg.current_proportional_gain == $past(i_apb.pwdata[22:13], 2) &&
    o_cfg.current_integral_gain == $past(i_apb.pwdata[12:3], 2) &&
    o_cfg.speed_proportional_gain[9:7] == $past(i_apb.pwdata[2:0], 2))
    else $error("gain fields");
endmodule
`default_nettype wire

// ===== verif/closed_loop_stop_and_gain_cfg_test.sv
/*
 self-checking bench of the closed-loop configuration bank over apb.
 assumes cl_cfg_pkg and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module closed_loop_stop_and_gain_cfg_test;
  logic i_clk_sys;
  logic i_rstn;
  cl_cfg_pkg::apb_req_s req;
  cl_cfg_pkg::apb_rsp_s rsp;
  logic [6:0] spd_low;
  logic [13:0] top_hz;
  cl_cfg_pkg::cl_cfg_s cfg;
  logic [31:0] r;
  logic [31:0] w;
  logic e;
  int n_errors;
  int total_checks;
  int cycles;
  int dur_ms[16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000, 10000, 15000};
  int pct_x10[16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100,
    50, 25};
  cl_cfg_regs i_cl_cfg_regs (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_apb(req), .o_apb(rsp),
    .i_speed_gain_low(spd_low), .i_top_speed_hz(top_hz), .o_cfg(cfg));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // run needs under 1000 cycles; a hang ends here
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
    @(posedge i_clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk_sys);
    req.penable <= 1'b1;
    do @(posedge i_clk_sys); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    i_rstn = 1'b0;
    req = '0;
    spd_low = 7'h2a;
    top_hz = 14'h2710;
    repeat (6) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    xfer(1'b0, 10'h228, 32'h0, r, e);
    chk(r, 32'h0);
    // every code of the method, duration and threshold fields; top speed 10000 Hz makes hz ten times pct_x10
    for (int i = 0; i < 16; i++) begin
      w = {i[0], i[2:0], i[3:0], i[3:0], 4'(15 - i), 8'(i * 17), 8'(~i)};
      xfer(1'b1, 10'h228, w, r, e);
      chk(e, 32'h0);
      repeat (2) @(posedge i_clk_sys);
      chk(cfg.motor_stop_method, i[2:0]);
      chk(cfg.stop_valid, !(i[2:0] inside {1, 6, 7}));
      chk(cfg.brake_stop, i[2:0] inside {2, 3, 5});
      chk(cfg.stop_brake_duration_ms, dur_ms[i]);
      chk(cfg.active_spindown_speed_level_x10, pct_x10[i]);
      chk(cfg.brake_speed_level_x10, pct_x10[15 - i]);
      chk(cfg.spindown_speed_hz, pct_x10[i] * 10);
      chk(cfg.brake_speed_hz, pct_x10[15 - i] * 10);
      chk({cfg.phase_resistance_code, cfg.phase_inductance_code}, w[15:0]);
      xfer(1'b0, 10'h228, 32'h0, r, e);
      chk(r, w);
    end
    $display("stop test done");
    // gains set, then zeroed for automatic calculation
    for (int k = 0; k < 2; k++) begin
      w = {1'b1, 8'ha5, k ? 20'h0 : 20'h12345, 3'h5};
      spd_low <= k ? 7'h7f : 7'h2a;
      xfer(1'b1, 10'h230, w, r, e);
      repeat (2) @(posedge i_clk_sys);
      chk(cfg.back_emf_constant_code, 8'ha5);
      chk(cfg.current_proportional_gain, w[22:13]);
      chk(cfg.current_integral_gain, w[12:3]);
      chk(cfg.current_gain_auto, k);
      chk(cfg.speed_proportional_gain, {3'h5, spd_low});
      xfer(1'b0, 10'h230, 32'h0, r, e);
      chk(r, w);
    end
    $display("gain test done");
    // unmapped place: error, reads zero, leaves the gain word alone
    xfer(1'b1, 10'h22c, 32'hffff_ffff, r, e);
    chk(e, 32'h1);
    xfer(1'b0, 10'h22c, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 32'h1);
    xfer(1'b0, 10'h230, 32'h0, r, e);
    chk(r, w);
    $display("unmapped test done");
    // status word is read-only: a write answers without error and changes nothing
    xfer(1'b1, 10'h240, 32'hffff_ffff, r, e);
    chk(e, 32'h0);
    xfer(1'b0, 10'h240, 32'h0, r, e);
    chk(r, {16'h0000, 1'b1, 1'b0, 1'b0, 3'h7, 3'h5, 7'h7f});
    $display("status test done");
    // reset in mid-run returns both words and the decode to zero codes
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    xfer(1'b0, 10'h228, 32'h0, r, e);
    chk(r, 32'h0);
    xfer(1'b0, 10'h230, 32'h0, r, e);
    chk(r, 32'h0);
    chk(cfg.stop_valid, 32'h1);
    chk(cfg.current_gain_auto, 32'h1);
    chk(cfg.stop_brake_duration_ms, 32'h1);
    $display("reset test done");
    test_done();
  end
endmodule
bind cl_cfg_regs cl_cfg_regs_assertions i_cl_cfg_regs_assertions (.i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn), .i_apb(i_apb), .o_apb(o_apb), .i_speed_gain_low(i_speed_gain_low),
  .i_top_speed_hz(i_top_speed_hz), .o_cfg(o_cfg));
`default_nettype wire
